/* tb/sbsp_peer.sv */
// Model of the external serial peripheral on the far side of the port.
// Assumes sck_w is the resolved clock pin level seen by both ends.
`timescale 1ns/1ps
module sbsp_peer (
   input wire logic clock_i,
   input wire logic sck_w,
   input wire logic so_i,
   output logic si_o,
   output logic sck_drv_o
);
   logic [7:0] tx_q = 8'h00;
   logic [7:0] rx_q = 8'h00;
   logic prev_q = 1'b1;
   int bits = 0;
   initial si_o = 1'b1;
   initial sck_drv_o = 1'b1;
   // Drive on the pin fall, capture on the pin rise; word rotates so it never runs dry
   always @(posedge clock_i) begin
      prev_q <= sck_w;
      if (prev_q && !sck_w) begin
         si_o <= tx_q[0];
         tx_q <= {tx_q[0], tx_q[7:1]};
      end
      if (!prev_q && sck_w) begin
         rx_q <= {so_i, rx_q[7:1]};
         bits <= bits + 1;
      end
   end
   // External frame; low held five cycles and high six, clock stands high between frames
   task burst(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clock_i);
         sck_drv_o <= 1'b0;
         repeat (5) @(posedge clock_i);
         sck_drv_o <= 1'b1;
         repeat (5) @(posedge clock_i);
      end
   endtask : burst
endmodule : sbsp_peer

/* tb/sbsp_port_sva.sv */
// Checker for the serial port: clock pin, data pin and transfer-done pulse.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module sbsp_port_sva
   import sbsp_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic sck_o,
   input wire logic sck_oe_o,
   input wire logic so_o,
   input wire logic transfer_done_irq_o
);
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   logic [2:0] sel_q;
   logic wr1;
   assign wr1 = psel_i && penable_i && pwrite_i && (paddr_i == OFS_CTRL_ONE);
   // Mirror of the clock select, taken from bus writes rather than from a register read
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         sel_q <= CK_SLOWEST;
      end else if (wr1) begin
         sel_q <= pwdata_i[2:0];
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   sequence s_low_half;
      !sck_o [*7] ##1 sck_o;
   endsequence
   sequence s_idle_high;
      sck_o [*2];
   endsequence
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   chk_pin_owner: assert property (
      sck_oe_o == (sel_q != CK_EXTERNAL)) else $error("clock pin owner wrong");
   chk_reserved_still: assert property (
      sel_q == CK_RESERVED && $past(sel_q) == CK_RESERVED |-> $stable(sck_o)) else $error("reserved code clocks");
   chk_half_period: assert property (
      $fell(sck_o) && sel_q == 3'h5 |=> s_low_half) else $error("half period wrong");
   chk_start_high: assert property (
      wr1 && pwdata_i[7:6] == 2'h2 && pwdata_i[2:0] == 3'h5 |=> sck_o [*7]) else $error("clock not high at start");
   chk_so_on_fall: assert property (
      $changed(so_o) && sck_oe_o && $past(sck_oe_o) |-> $fell(sck_o)) else $error("data moved off falling edge");
   chk_irq_after_rise: assert property (
      transfer_done_irq_o && sck_oe_o |-> sck_o && !$past(sck_o)) else $error("done pulse not with rise");
   chk_irq_single: assert property (
      transfer_done_irq_o |=> !transfer_done_irq_o) else $error("done pulse too long");
   chk_abort_idle: assert property (
      wr1 && pwdata_i[6] |-> ##[1:2] s_idle_high) else $error("abort did not idle clock");
endmodule : sbsp_port_sva

bind sbsp_port sbsp_port_sva chk_u (.clock_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
   .sck_o, .sck_oe_o, .so_o, .transfer_done_irq_o);

/* tb/sbsp_port_tb.sv */
// Self-checking bench: APB master, serial peer and scenario tasks.
// Assumes the peer model and checker are compiled before this file.
`timescale 1ns/1ps
module sbsp_port_tb
   import sbsp_pkg::*;
;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0;
   logic [31:0] prdata_o, rdata;
   logic pready_o, pslverr_o, slverr, sck_o, sck_oe_o, so_o, si_w, peer_sck, sck_w, irq;
   logic lfc = 1'b0;
   int error_cnt = 0;
   int cmp_count = 0;
   always #5 clock_i = ~clock_i;
   always #700 lfc = ~lfc;
   // Pin level: the port owns it unless the external clock is selected
   assign sck_w = sck_oe_o ? sck_o : peer_sck;
   sbsp_port dut_u (.clock_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
      .pready_o, .pslverr_o, .low_freq_clk_i(lfc), .sck_i(sck_w), .sck_o, .sck_oe_o, .si_i(si_w), .so_o,
      .transfer_done_irq_o(irq));
   sbsp_peer peer_u (.clock_i, .sck_w, .so_i(so_o), .si_o(si_w), .sck_drv_o(peer_sck));
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clock_i);
      penable_i <= 1'b1;
      do @(posedge clock_i); while (pready_o !== 1'b1);
      rdata = prdata_o;
      slverr = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb
   function logic [31:0] c1(input logic g, input logic ab, input logic [2:0] m, input logic [2:0] s);
      return {24'h0, g, ab, m, s};
   endfunction : c1
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // Bounded waits; polling the busy flag keeps the bus in use meanwhile
   task wait_idle;
      for (int i = 0; i < 200; i++) begin
         apb(1'b0, OFS_STATE, 32'h0);
         if (rdata[ST_BUSY_BIT] === 1'b0) break;
      end
   endtask : wait_idle
   task wirq;
      for (int i = 0; i < 3000 && irq !== 1'b1; i++) @(negedge clock_i);
      // The peer captures the last bit one cycle after the pulse
      repeat (2) @(negedge clock_i);
   endtask : wirq
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task t_reset;
      apb(1'b0, OFS_STATE, 32'h0);
      chk("state", 8'h00, rdata[7:0]);
      apb(1'b0, 12'h0fc, 32'h0);
      chk("slverr", 8'h01, {7'h0, slverr});
      chk("pins", 8'h03, {6'h0, sck_o, so_o});
   endtask : t_reset
   task t_tx;
      int b0;
      apb(1'b1, OFS_CTRL_ONE, c1(1'b0, 1'b1, MODE_TX8, 3'h5));
      apb(1'b1, OFS_CTRL_TWO, 32'h1);
      apb(1'b1, OFS_BUF_BASE, 32'ha5);
      apb(1'b1, OFS_BUF_BASE + 12'h004, 32'h3c);
      b0 = peer_u.bits;
      apb(1'b1, OFS_CTRL_ONE, c1(1'b1, 1'b0, MODE_TX8, 3'h5));
      wirq;
      chk("tx word", 8'h3c, peer_u.rx_q);
      chk("tx bits", 8'h10, 8'(peer_u.bits - b0));
      apb(1'b0, OFS_STATE, 32'h0);
      chk("tx wait", 8'h01, {7'h0, rdata[ST_WAIT_BIT]});
      apb(1'b1, OFS_CTRL_TWO, 32'h0);
      apb(1'b1, OFS_BUF_BASE + 12'h01c, 32'h0);
      wirq;
      chk("tx recount", 8'ha5, peer_u.rx_q);
      apb(1'b1, OFS_CTRL_ONE, c1(1'b0, 1'b0, MODE_TX8, 3'h5));
      wait_idle;
      chk("tx busy", 8'h00, {7'h0, rdata[ST_BUSY_BIT]});
   endtask : t_tx
   task t_rx4;
      apb(1'b1, OFS_CTRL_ONE, c1(1'b0, 1'b1, MODE_RX4, 3'h5));
      apb(1'b1, OFS_CTRL_TWO, 32'h0);
      peer_u.tx_q = 8'h5b;
      apb(1'b1, OFS_CTRL_ONE, c1(1'b1, 1'b0, MODE_RX4, 3'h5));
      wirq;
      apb(1'b0, OFS_BUF_BASE, 32'h0);
      chk("rx word", 8'h0b, rdata[7:0]);
      apb(1'b1, OFS_CTRL_ONE, c1(1'b0, 1'b0, MODE_RX4, 3'h5));
      wait_idle;
      apb(1'b0, OFS_BUF_BASE, 32'h0);
      chk("rx last", 8'h05, rdata[7:0]);
   endtask : t_rx4
   task t_abort;
      apb(1'b1, OFS_CTRL_ONE, c1(1'b0, 1'b1, MODE_RX8, 3'h4));
      apb(1'b1, OFS_CTRL_ONE, c1(1'b1, 1'b0, MODE_RX8, 3'h4));
      repeat (40) @(posedge clock_i);
      apb(1'b0, OFS_STATE, 32'h0);
      chk("busy", 8'h01, {7'h0, rdata[ST_BUSY_BIT]});
      apb(1'b1, OFS_CTRL_ONE, c1(1'b0, 1'b1, MODE_RX8, 3'h4));
      apb(1'b0, OFS_STATE, 32'h0);
      chk("abort busy", 8'h00, {7'h0, rdata[ST_BUSY_BIT]});
   endtask : t_abort
   task t_ext;
      apb(1'b1, OFS_CTRL_ONE, c1(1'b0, 1'b1, MODE_TX8, CK_EXTERNAL));
      apb(1'b1, OFS_BUF_BASE, 32'hc3);
      apb(1'b1, OFS_CTRL_ONE, c1(1'b1, 1'b0, MODE_TX8, CK_EXTERNAL));
      peer_u.burst(8);
      chk("ext word", 8'hc3, peer_u.rx_q);
      peer_u.burst(8);
      chk("ext dummy", DUMMY_WORD, peer_u.rx_q);
      wait_idle;
      chk("ext busy", 8'h00, {7'h0, rdata[ST_BUSY_BIT]});
   endtask : t_ext
   task t_res6;
      apb(1'b1, OFS_CTRL_ONE, c1(1'b0, 1'b1, MODE_TX8, CK_RESERVED));
      apb(1'b1, OFS_CTRL_ONE, c1(1'b1, 1'b0, MODE_TX8, CK_RESERVED));
      repeat (64) @(negedge clock_i);
      chk("reserved sck", 8'h01, {7'h0, sck_o});
      apb(1'b1, OFS_CTRL_ONE, c1(1'b0, 1'b1, MODE_TX8, 3'h5));
   endtask : t_res6
   task t_mode;
      apb(1'b1, OFS_BUF_BASE + 12'h008, 32'h77);
      apb(1'b1, OFS_CTRL_ONE, c1(1'b0, 1'b1, MODE_RX8, 3'h5));
      apb(1'b0, OFS_BUF_BASE + 12'h008, 32'h0);
      chk("mode clears", 8'h00, rdata[7:0]);
   endtask : t_mode
   task conclude;
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   // Main sequence after four cycles of reset
   initial begin
      repeat (4) @(posedge clock_i);
      rst_i <= 1'b0;
      t_reset;
      t_tx;
      t_rx4;
      t_abort;
      t_ext;
      t_res6;
      t_mode;
      conclude;
   end
   // Watchdog well beyond the expected run of under 2k cycles
   initial begin
      #400000;
      error_cnt++;
      conclude;
   end
endmodule : sbsp_port_tb

/* verilog/sbsp_clk_if.sv */
// Carrier between the port engine and its serial clock generator.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface sbsp_clk_if;
   logic [2:0] sel; // clock select code
   logic div_src; // divider_source_sel
   logic low_speed; // low_speed_mode
   logic run; // engine is shifting on the internal clock
   logic tick; // one half period of the serial clock elapsed

   modport eng (output sel, output div_src, output low_speed, output run, input tick);
   modport gen (input sel, input div_src, input low_speed, input run, output tick);
endinterface : sbsp_clk_if

/* verilog/sbsp_clkgen.sv */
// Internal serial clock generator: half-period ticks from the high or low clock.
// Assumes low_freq_clk_i is asynchronous and much slower than clock_i.
`timescale 1ns/1ps
module sbsp_clkgen
   import sbsp_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic low_freq_clk_i,
   sbsp_clk_if.gen cif
);

   logic [2:0] low_sync_q;
   logic [12:0] cnt_q;
   logic [12:0] half;
   logic low_mode;
   logic step;

   // ---------------------------------------------------------------------
   // Half period in counted edges for each select code
   // ---------------------------------------------------------------------
   function automatic logic [12:0] half_count(input logic [2:0] code, input logic use_low);
      logic [3:0] expo;
      expo = DIV_EXP_TOP - {1'b0, code};
      if (code == CK_SLOWEST) begin
         expo = use_low ? DIV_EXP_LOW : DIV_EXP_SLOWEST;
      end
      half_count = 13'(13'h1 << (expo - 4'h1));
   endfunction : half_count

   // Two flops before the edge detector sees the low clock
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         low_sync_q <= 3'h0;
      end else begin
         low_sync_q <= {low_sync_q[1:0], low_freq_clk_i};
      end
   end

   // Code 000 falls back to the low clock on request or in low-speed mode
   assign low_mode = (cif.sel == CK_SLOWEST) && (cif.div_src || cif.low_speed);
   assign half = half_count(cif.sel, low_mode);
   assign step = low_mode ? (low_sync_q[1] & ~low_sync_q[2]) : 1'b1;

   // Counter restarts whenever the engine stops, so the first half period is whole
   always_ff @(posedge clock_i) begin
      if (rst_i || !cif.run) begin
         cnt_q <= 13'h0;
      end else if (step) begin
         cnt_q <= (cnt_q == half - 13'h1) ? 13'h0 : cnt_q + 13'h1;
      end
   end

   // Reserved and external codes never tick
   assign cif.tick = cif.run && step && (cnt_q == half - 13'h1) &&
                     (cif.sel != CK_RESERVED) && (cif.sel != CK_EXTERNAL);

endmodule : sbsp_clkgen

/* verilog/sbsp_pkg.sv */
// Constants, register map and field layout of the buffered synchronous serial port.
// Assumes a 100 MHz system clock that is also the high frequency clock of the port.
package sbsp_pkg;

   // ----------------------------------------------------------------------
   // Register offsets (byte addresses on the APB side)
   // ----------------------------------------------------------------------
   localparam logic [11:0] OFS_CTRL_ONE = 12'h000; // serial_ctrl_one
   localparam logic [11:0] OFS_CTRL_TWO = 12'h004; // serial_ctrl_two
   localparam logic [11:0] OFS_STATE = 12'h008; // serial_state_reg
   localparam logic [11:0] OFS_BUF_BASE = 12'h020; // word_buffer 0..7 at 0x20..0x3c
   localparam int BUF_WORDS = 8;

   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int C1_CLK_LSB = 0; // 3-bit clock select
   localparam int C1_MODE_LSB = 3; // 3-bit transfer_mode_sel
   localparam int C1_ABORT_BIT = 6; // transfer_abort_bit
   localparam int C1_GO_BIT = 7; // transfer_go_bit
   localparam int C2_CNT_LSB = 0; // 3-bit word count minus one
   localparam int C2_FRAME_LSB = 3; // 2-bit frame wait, stored only
   localparam int C2_DIVSRC_BIT = 5; // divider_source_sel
   localparam int C2_LOWSPD_BIT = 6; // low_speed_mode
   localparam int ST_PEND_BIT = 0; // transmit data written since batch start
   localparam int ST_FULL_BIT = 1; // receive buffer holds unread batch
   localparam int ST_WAIT_BIT = 2; // automatic wait in progress
   localparam int ST_SHIFT_BIT = 6; // shift operation in process
   localparam int ST_BUSY_BIT = 7; // transfer_busy_flag

   localparam logic [7:0] CTRL_ONE_RST = 8'h00;
   localparam logic [6:0] CTRL_TWO_RST = 7'h00;

   // ----------------------------------------------------------------------
   // Clock select codes and divider exponents
   // ----------------------------------------------------------------------
   localparam logic [2:0] CK_SLOWEST = 3'h0;
   localparam logic [2:0] CK_RESERVED = 3'h6;
   localparam logic [2:0] CK_EXTERNAL = 3'h7;
   localparam logic [3:0] DIV_EXP_SLOWEST = 4'hd; // high clock / 2^13
   localparam logic [3:0] DIV_EXP_LOW = 4'h5; // low clock / 2^5
   localparam logic [3:0] DIV_EXP_TOP = 4'h9; // code 001 gives 2^8, one less per step

   // ----------------------------------------------------------------------
   // Transfer modes
   // ----------------------------------------------------------------------
   localparam logic [2:0] MODE_TX8 = 3'h0;
   localparam logic [2:0] MODE_TX4 = 3'h2;
   localparam logic [2:0] MODE_TXRX8 = 3'h4;
   localparam logic [2:0] MODE_RX8 = 3'h5;
   localparam logic [2:0] MODE_RX4 = 3'h6;

   localparam logic [7:0] DUMMY_WORD = 8'hff;

   typedef enum logic [1:0] {
      SBSP_IDLE = 2'h0,
      SBSP_RUN = 2'h1,
      SBSP_WAIT = 2'h3
   } sbsp_state_type;

endpackage : sbsp_pkg

/* verilog/sbsp_port.sv */
// Buffered synchronous serial port: APB registers, eight word buffer, shift engine.
// Assumes an APB master on clock_i; serial pins are asynchronous to clock_i.
//
// Summary of operation
// - Clock select: internal codes, 110 reserved, 111 external
// - Six internal rates from high or low clock
// - Internal clock driven out, pin idles high
// - Internal clock stops while buffer access lags
// - Shift out on falling, sample on rising
// - Four-bit words use low nibble, upper zero
// - Bits move least significant first
// - One to eight words, interrupt after count
// - Next buffer word loads once current finishes
// - Buffer-empty interrupt after last transmit word
// - Internal transmit waits until a word is written
// - Any buffer write releases the wait
// - Cleared start finishes current word, then idles
// - Abort ends transmission and busy at once
// - External transmit without data sends dummy, ends
// - Received words stored, buffer-full interrupt after count
// - Internal receive waits until a word is read
// - External receive with unread data cancels reception
// - Cleared start stores current word, then idles
// - Abort ends reception, partial word dropped
// - Changing transfer mode clears the buffer
// - Buffer used from lowest address upward
`timescale 1ns/1ps
module sbsp_port
   import sbsp_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic low_freq_clk_i,
   input wire logic sck_i,
   output logic sck_o,
   output logic sck_oe_o,
   input wire logic si_i,
   output logic so_o,
   output logic transfer_done_irq_o
);

   // ---------------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------------
   sbsp_clk_if cif ();
   sbsp_state_type state_q;
   logic [7:0] buf_q [BUF_WORDS];
   logic [7:0] ctrl_one_q;
   logic [6:0] ctrl_two_q;
   logic [31:0] prdata_q;
   logic [2:0] idx_q;
   logic [2:0] bit_q;
   logic [7:0] tx_sh_q;
   logic [7:0] rx_sh_q;
   logic sck_q;
   logic so_q;
   logic pend_q;
   logic full_q;
   logic dummy_q;
   logic irq_q;
   logic [2:0] sck_sync_q;
   logic [1:0] si_sync_q;
   logic access;
   logic wr_c1;
   logic wr_c2;
   logic wr_buf;
   logic rd_buf;
   logic [2:0] bidx;
   logic start_wr;
   logic abort_wr;
   logic mode_wr;
   logic [2:0] ck_sel;
   logic [2:0] mode;
   logic [2:0] last_idx;
   logic ext_clk;
   logic go;
   logic tx_on;
   logic rx_on;
   logic word8;
   logic fall_ev;
   logic rise_ev;
   logic word_done;
   logic last_word;
   logic cancel;
   logic end_ev;
   logic store_ev;
   logic [7:0] rx_next;
   logic [7:0] status;

   // ---------------------------------------------------------------------
   // Decode helpers
   // ---------------------------------------------------------------------
   function automatic logic buf_hit(input logic [11:0] addr);
      buf_hit = (addr[11:5] == OFS_BUF_BASE[11:5]) && (addr[1:0] == 2'h0);
   endfunction : buf_hit

   function automatic logic mode_tx(input logic [2:0] m);
      mode_tx = (m == MODE_TX8) || (m == MODE_TX4) || (m == MODE_TXRX8);
   endfunction : mode_tx

   function automatic logic mode_rx(input logic [2:0] m);
      mode_rx = (m == MODE_RX8) || (m == MODE_RX4) || (m == MODE_TXRX8);
   endfunction : mode_rx

   // ---------------------------------------------------------------------
   // APB slave: zero wait states, read data captured in the setup cycle
   // ---------------------------------------------------------------------
   assign access = psel_i && penable_i;
   assign bidx = paddr_i[4:2];
   assign wr_c1 = access && pwrite_i && (paddr_i == OFS_CTRL_ONE);
   assign wr_c2 = access && pwrite_i && (paddr_i == OFS_CTRL_TWO);
   assign wr_buf = access && pwrite_i && buf_hit(paddr_i);
   assign rd_buf = access && !pwrite_i && buf_hit(paddr_i);
   assign pready_o = 1'b1;
   assign pslverr_o = access && !buf_hit(paddr_i) && (paddr_i != OFS_CTRL_ONE) &&
                      (paddr_i != OFS_CTRL_TWO) && (paddr_i != OFS_STATE);
   assign prdata_o = prdata_q;

   // Status word: busy and shifting in the top bits, flow flags below
   always_comb begin
      status = 8'h00;
      status[ST_BUSY_BIT] = (state_q != SBSP_IDLE);
      status[ST_SHIFT_BIT] = (state_q == SBSP_RUN);
      status[ST_WAIT_BIT] = (state_q == SBSP_WAIT);
      status[ST_FULL_BIT] = full_q;
      status[ST_PEND_BIT] = pend_q;
   end

   // Read mux sampled during setup so the data stands through the access phase
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         prdata_q <= 32'h0;
      end else if (psel_i && !penable_i && !pwrite_i) begin
         if (paddr_i == OFS_CTRL_ONE) begin
            prdata_q <= {24'h0, ctrl_one_q};
         end else if (paddr_i == OFS_CTRL_TWO) begin
            prdata_q <= {25'h0, ctrl_two_q};
         end else if (paddr_i == OFS_STATE) begin
            prdata_q <= {24'h0, status};
         end else if (buf_hit(paddr_i)) begin
            prdata_q <= {24'h0, buf_q[bidx]};
         end else begin
            prdata_q <= 32'h0;
         end
      end
   end

   // ---------------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------------
   assign ck_sel = ctrl_one_q[C1_CLK_LSB +: 3];
   assign mode = ctrl_one_q[C1_MODE_LSB +: 3];
   assign go = ctrl_one_q[C1_GO_BIT];
   assign last_idx = ctrl_two_q[C2_CNT_LSB +: 3];
   assign ext_clk = (ck_sel == CK_EXTERNAL);
   assign tx_on = mode_tx(mode);
   assign rx_on = mode_rx(mode);
   assign word8 = (mode != MODE_TX4) && (mode != MODE_RX4);
   assign start_wr = wr_c1 && pwdata_i[C1_GO_BIT] && !pwdata_i[C1_ABORT_BIT] && (state_q == SBSP_IDLE);
   assign abort_wr = wr_c1 && pwdata_i[C1_ABORT_BIT];
   assign mode_wr = wr_c1 && (pwdata_i[C1_MODE_LSB +: 3] != mode);

   // The start bit falls when the engine finishes; the abort bit lasts one cycle
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         ctrl_one_q <= CTRL_ONE_RST;
         ctrl_two_q <= CTRL_TWO_RST;
      end else begin
         ctrl_one_q[C1_ABORT_BIT] <= 1'b0;
         if (end_ev) begin
            ctrl_one_q[C1_GO_BIT] <= 1'b0;
         end
         if (wr_c1) begin
            ctrl_one_q <= pwdata_i[7:0];
         end
         if (wr_c2) begin
            ctrl_two_q <= pwdata_i[6:0];
         end
      end
   end

   // ---------------------------------------------------------------------
   // Serial pins and clock generator
   // ---------------------------------------------------------------------
   // Two flops on each incoming pin before any logic looks at it
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         sck_sync_q <= 3'h7;
         si_sync_q <= 2'h0;
      end else begin
         sck_sync_q <= {sck_sync_q[1:0], sck_i};
         si_sync_q <= {si_sync_q[0], si_i};
      end
   end

   assign cif.sel = ck_sel;
   assign cif.div_src = ctrl_two_q[C2_DIVSRC_BIT];
   assign cif.low_speed = ctrl_two_q[C2_LOWSPD_BIT];
   assign cif.run = (state_q == SBSP_RUN) && !ext_clk;

   sbsp_clkgen u_clkgen (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .low_freq_clk_i(low_freq_clk_i),
      .cif(cif)
   );

   // Edges of the serial clock, internal or external, seen only while running
   assign fall_ev = (state_q == SBSP_RUN) &&
                    (ext_clk ? (sck_sync_q[2] && !sck_sync_q[1]) : (cif.tick && sck_q));
   assign rise_ev = (state_q == SBSP_RUN) &&
                    (ext_clk ? (!sck_sync_q[2] && sck_sync_q[1]) : (cif.tick && !sck_q));
   assign word_done = rise_ev && (bit_q == (word8 ? 3'h7 : 3'h3));
   assign last_word = (idx_q == last_idx);
   assign cancel = rx_on && ext_clk && full_q && !rd_buf;
   assign end_ev = word_done && (dummy_q || cancel || !go);
   assign store_ev = word_done && rx_on && !cancel && !dummy_q;

   // New bit enters at the top of the word, so the first one lands in bit 0
   assign rx_next = word8 ? {si_sync_q[1], rx_sh_q[7:1]} : {4'h0, si_sync_q[1], rx_sh_q[3:1]};

   assign sck_o = sck_q;
   assign sck_oe_o = !ext_clk;
   assign so_o = so_q;
   assign transfer_done_irq_o = irq_q;

   // ---------------------------------------------------------------------
   // Word buffer
   // ---------------------------------------------------------------------
   // A received word wins over a software write to the same slot
   always_ff @(posedge clock_i) begin
      if (rst_i || mode_wr) begin
         for (int i = 0; i < BUF_WORDS; i++) begin
            buf_q[i] <= 8'h00;
         end
      end else begin
         if (wr_buf) begin
            buf_q[bidx] <= pwdata_i[7:0];
         end
         if (store_ev) begin
            buf_q[idx_q] <= rx_next;
         end
      end
   end

   // ---------------------------------------------------------------------
   // Shift engine
   // ---------------------------------------------------------------------
   // Flag clears come first so a hardware set in the same cycle wins
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         state_q <= SBSP_IDLE;
         idx_q <= 3'h0;
         bit_q <= 3'h0;
         tx_sh_q <= 8'h00;
         rx_sh_q <= 8'h00;
         sck_q <= 1'b1;
         so_q <= 1'b1;
         pend_q <= 1'b0;
         full_q <= 1'b0;
         dummy_q <= 1'b0;
         irq_q <= 1'b0;
      end else if (abort_wr || mode_wr) begin
         state_q <= SBSP_IDLE;
         sck_q <= 1'b1;
         dummy_q <= 1'b0;
         bit_q <= 3'h0;
         irq_q <= 1'b0;
      end else begin
         irq_q <= 1'b0;
         if (rd_buf) begin
            full_q <= 1'b0;
         end
         case (state_q)
            SBSP_IDLE: begin
               if (start_wr) begin
                  state_q <= SBSP_RUN;
                  idx_q <= 3'h0;
                  bit_q <= 3'h0;
                  tx_sh_q <= buf_q[0];
                  sck_q <= 1'b1;
                  pend_q <= 1'b0;
                  full_q <= 1'b0;
                  dummy_q <= 1'b0;
               end
            end
            SBSP_RUN: begin
               if (!ext_clk && cif.tick) begin
                  sck_q <= !sck_q;
               end
               if (fall_ev) begin
                  so_q <= tx_on ? tx_sh_q[0] : 1'b1;
                  tx_sh_q <= {1'b1, tx_sh_q[7:1]};
               end
               if (rise_ev) begin
                  rx_sh_q <= rx_next;
                  bit_q <= bit_q + 3'h1;
               end
               if (word_done) begin
                  bit_q <= 3'h0;
                  irq_q <= last_word && !cancel && !dummy_q;
                  if (end_ev) begin
                     state_q <= SBSP_IDLE;
                     dummy_q <= 1'b0;
                  end else if (!last_word) begin
                     idx_q <= idx_q + 3'h1;
                     tx_sh_q <= buf_q[idx_q + 3'h1];
                  end else begin
                     idx_q <= 3'h0;
                     if (rx_on) begin
                        full_q <= 1'b1;
                     end
                     if (tx_on && pend_q) begin
                        tx_sh_q <= buf_q[0];
                        pend_q <= 1'b0;
                     end else if (!ext_clk) begin
                        state_q <= SBSP_WAIT;
                     end else if (tx_on) begin
                        dummy_q <= 1'b1;
                        tx_sh_q <= DUMMY_WORD;
                     end
                  end
               end
            end
            SBSP_WAIT: begin
               // Clock parked high; a buffer write (transmit modes) or a buffer read (receive-only modes) lets it run again
               if (!go) begin
                  state_q <= SBSP_IDLE;
               end else if (tx_on ? pend_q : !full_q) begin
                  state_q <= SBSP_RUN;
                  tx_sh_q <= buf_q[0];
                  pend_q <= 1'b0;
               end
            end
            default: begin
               state_q <= SBSP_IDLE;
            end
         endcase
         if (wr_buf) begin
            pend_q <= 1'b1;
         end
      end
   end

endmodule : sbsp_port
